/* File: logic/alarm_io_defs.vh */
`ifndef ALARM_IO_DEFS_VH
`define ALARM_IO_DEFS_VH

// Clock rate in kHz and update period in ms.
`define CLOCK_KHZ 125000
`define UPDATE_MS 200
// Update period in clock cycles.
`define UPDATE_CYCLES (`UPDATE_MS * `CLOCK_KHZ)
// Calibration request pulse window in ms.
`define CAL_PULSE_MIN_MS 1000
`define CAL_PULSE_MAX_MS 2000
// Window expressed in update ticks.
`define CAL_TICKS_MIN (`CAL_PULSE_MIN_MS / `UPDATE_MS)
`define CAL_TICKS_MAX (`CAL_PULSE_MAX_MS / `UPDATE_MS)
// Debounce settle count in clock cycles.
`define DEBOUNCE_CYCLES 16'h1000
// Relay output bit positions.
`define RLY_MAINT 0
`define RLY_CUSTOM 1
`define RLY_FAIL 2
`define RLY_VALID 3
`define RLY_PRE 4
`define RLY_CAL 5
`define RLY_ALARM 6
// Number of relay outputs and debounced inputs.
`define NUM_RELAYS 7
`define NUM_INPUTS 9
// Input bit positions in the debounced vector.
`define IN_ALARM_RESET 0
`define IN_LAMP_TEST 1
`define IN_SERVICE 2
`define IN_MAINT_BLOCK 3
`define IN_CAL_LINE 4
`define IN_GAS_FAULT 5
`define IN_EXT_FAULT 6
`define IN_MEAS_REQ 7
`define IN_CAL_REQ 8
// Inverting mask for closed-when-inactive relays.
`define RLY_INVERT_MASK 7'h54

`endif

/* File: logic/input_debounce.v */
`include "alarm_io_defs.vh"

module input_debounce
#(
  parameter WIDTH = 9,
  parameter SETTLE = 16'h1000
)
(
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] raw,
  output reg [WIDTH-1:0] clean
);

  reg [WIDTH-1:0] sync_a;
  reg [WIDTH-1:0] sync_b;
  reg [WIDTH-1:0] sync_c;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= {WIDTH{1'b0}};
      sync_b <= {WIDTH{1'b0}};
      sync_c <= {WIDTH{1'b0}};
    end
    else
    begin
      sync_a <= raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : bit_filter
      reg [15:0] count;
      // A change counts only when stages two and three agree and hold.
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          count <= 16'h0000;
          clean[i] <= 1'b0;
        end
        else if (sync_b[i] != sync_c[i] || sync_c[i] == clean[i])
          count <= 16'h0000;
        else if (count == SETTLE)
        begin
          count <= 16'h0000;
          clean[i] <= sync_c[i];
        end
        else
          count <= count + 16'h0001;
      end
    end
  endgenerate

endmodule

/* File: logic/alarm_status_io.v */

`include "alarm_io_defs.vh"

module alarm_status_io
#(
  parameter UPDATE_CYCLES = `UPDATE_CYCLES,
  parameter DEBOUNCE = `DEBOUNCE_CYCLES,
  parameter CAL_MIN = `CAL_TICKS_MIN,
  parameter CAL_MAX = `CAL_TICKS_MAX
)
(
  input wire CLOCK,
  input wire RSTN,
  input wire ALARM_RESET,
  input wire LAMP_TEST,
  input wire SERVICE_SWITCH,
  input wire MAINT_BLOCK,
  input wire CAL_LINE,
  input wire GAS_FAULT,
  input wire EXT_FAULT,
  input wire MEAS_STOP_REQ,
  input wire MENU_CAL_REQ,
  input wire SEL_SERVICE_REQUIREMENT,
  input wire SEL_LOW_PRE_ALARM,
  input wire SEL_LOW_ALARM,
  input wire ALARM_MODE_SELECT,
  input wire CUSTOM_LAMP_POLARITY_SELECT,
  input wire EXT_MALFUNCTION_DISABLE,
  input wire EXTERNAL_AUTO_CALIBRATION_MODE,
  input wire UNIT_MAINTENANCE,
  input wire UNIT_SERVICE_REQ,
  input wire UNIT_FAILURE,
  input wire UNIT_VALID,
  input wire UNIT_PRE_ALARM,
  input wire UNIT_LOW_PRE_ALARM,
  input wire UNIT_LOW_ALARM,
  input wire UNIT_CALIBRATING,
  input wire UNIT_ALARM,
  input wire UNIT_MEASURING,
  output reg [6:0] RELAY_CLOSED,
  output reg [6:0] LAMP_ON,
  output reg CAL_START,
  output reg MEAS_STOP_GRANT,
  output reg SERVICE_REQ_STATUS,
  output reg SELECT_ERROR
);

  //////////////////////////////////////////////////////////////////////////
  // synchronise and debounce
  wire [`NUM_INPUTS-1:0] raw_in;
  wire [`NUM_INPUTS-1:0] din;

  assign raw_in = {MENU_CAL_REQ, MEAS_STOP_REQ, EXT_FAULT, GAS_FAULT,
                   CAL_LINE, MAINT_BLOCK, SERVICE_SWITCH, LAMP_TEST,
                   ALARM_RESET};

  input_debounce #(
    .WIDTH(`NUM_INPUTS),
    .SETTLE(DEBOUNCE)
  ) debounce_inst (
    .clk(CLOCK),
    .rst_n(RSTN),
    .raw(raw_in),
    .clean(din)
  );

  // Jumpers and unit status are static or same-domain; they skip the debounce counter.
  reg [13:0] jmp_a;
  reg [13:0] jmp_b;
  reg [13:0] jmp_c;
  reg [13:0] jmp;
  wire [13:0] jmp_raw;

  assign jmp_raw = {UNIT_MEASURING, UNIT_ALARM, UNIT_CALIBRATING,
                    UNIT_LOW_ALARM, UNIT_LOW_PRE_ALARM, UNIT_PRE_ALARM,
                    UNIT_VALID, UNIT_FAILURE, UNIT_SERVICE_REQ,
                    UNIT_MAINTENANCE, SEL_LOW_ALARM, SEL_LOW_PRE_ALARM,
                    SEL_SERVICE_REQUIREMENT, ALARM_MODE_SELECT};

  // Pin inputs pass three flops; a change counts when stages two and three agree.
  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      jmp_a <= 14'h0000;
      jmp_b <= 14'h0000;
      jmp_c <= 14'h0000;
      jmp <= 14'h0000;
    end
    else
    begin
      jmp_a <= jmp_raw;
      jmp_b <= jmp_a;
      jmp_c <= jmp_b;
      jmp <= (jmp_b & jmp_c) | (jmp & (jmp_b | jmp_c));
    end
  end

  reg [2:0] misc_a;
  reg [2:0] misc_b;
  reg [2:0] misc_c;
  reg [2:0] misc;

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      misc_a <= 3'h0;
      misc_b <= 3'h0;
      misc_c <= 3'h0;
      misc <= 3'h0;
    end
    else
    begin
      misc_a <= {EXTERNAL_AUTO_CALIBRATION_MODE, EXT_MALFUNCTION_DISABLE,
                 CUSTOM_LAMP_POLARITY_SELECT};
      misc_b <= misc_a;
      misc_c <= misc_b;
      misc <= (misc_b & misc_c) | (misc & (misc_b | misc_c));
    end
  end

  wire auto_mode;
  wire sel_svc;
  wire sel_lpre;
  wire sel_lalm;
  wire u_maint;
  wire u_svc;
  wire u_fail;
  wire u_valid;
  wire u_pre;
  wire u_lpre;
  wire u_lalm;
  wire u_cal;
  wire u_alarm;
  wire u_meas;
  wire lamp_invert;
  wire ext_disable;
  wire ext_auto;

  // Low level on the mode select is position 1-2, automatic clearing.
  assign auto_mode = ~jmp[0];
  assign sel_svc = jmp[1];
  assign sel_lpre = jmp[2];
  assign sel_lalm = jmp[3];
  assign u_maint = jmp[4];
  assign u_svc = jmp[5];
  assign u_fail = jmp[6];
  assign u_valid = jmp[7];
  assign u_pre = jmp[8];
  assign u_lpre = jmp[9];
  assign u_lalm = jmp[10];
  assign u_cal = jmp[11];
  assign u_alarm = jmp[12];
  assign u_meas = jmp[13];
  assign lamp_invert = misc[0];
  assign ext_disable = misc[1];
  assign ext_auto = misc[2];

  //////////////////////////////////////////////////////////////////////////
  // update period tick
  reg [31:0] tick_count;
  reg tick;

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tick_count <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (tick_count == UPDATE_CYCLES - 1)
    begin
      tick_count <= 32'h00000000;
      tick <= 1'b1;
    end
    else
    begin
      tick_count <= tick_count + 32'h00000001;
      tick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Alarm latch and commissioning state.
  reg alarm_latch;
  reg commissioning;
  wire service_mode;
  wire service_status;

  assign service_mode = din[`IN_SERVICE];
  assign service_status = u_svc | din[`IN_GAS_FAULT];

  // Commissioning starts active at reset so the safety contact opens at once.
  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      alarm_latch <= 1'b1;
      commissioning <= 1'b1;
    end
    else if (tick)
    begin
      if (u_meas)
        commissioning <= 1'b0;
      if (u_alarm)
        alarm_latch <= 1'b1;
      else if (din[`IN_ALARM_RESET])
        alarm_latch <= 1'b0;
      else if (commissioning && u_meas && auto_mode)
        alarm_latch <= 1'b0;
      else
        alarm_latch <= alarm_latch;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // customer function select
  reg custom_sig;
  reg sel_bad;

  always @*
  begin
    sel_bad = (sel_svc + sel_lpre + sel_lalm) != 2'h1;
    if (sel_lpre && !sel_svc && !sel_lalm)
      custom_sig = u_lpre;
    else if (sel_lalm && !sel_svc && !sel_lpre)
      custom_sig = u_lalm;
    else
      custom_sig = service_status;
  end

  // Active-level status vector before contact polarity.
  reg [6:0] active;

  always @*
  begin
    active[`RLY_MAINT] = u_maint;
    active[`RLY_CUSTOM] = custom_sig;
    active[`RLY_FAIL] = u_fail | (din[`IN_EXT_FAULT] & ~ext_disable);
    active[`RLY_VALID] = u_valid;
    active[`RLY_PRE] = u_pre;
    active[`RLY_CAL] = u_cal;
    active[`RLY_ALARM] = alarm_latch | commissioning;
    if (service_mode)
    begin
      active[`RLY_MAINT] = 1'b0;
      active[`RLY_FAIL] = 1'b0;
      active[`RLY_VALID] = 1'b1;
      active[`RLY_PRE] = 1'b1;
      active[`RLY_ALARM] = u_alarm;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // external calibration pulse
  reg [7:0] low_ticks;
  reg cal_pending;
  wire cal_low;

  assign cal_low = ~din[`IN_CAL_LINE];

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      low_ticks <= 8'h00;
      cal_pending <= 1'b0;
    end
    else
    begin
      cal_pending <= 1'b0;
      if (tick)
      begin
        if (!cal_low || !ext_auto)
          low_ticks <= 8'h00;
        else if (low_ticks != CAL_MAX[7:0])
          low_ticks <= low_ticks + 8'h01;
        // Start while the line is still low, since a high line reads as a
        // block; a pulse held past the window therefore also starts once.
        if (ext_auto && cal_low && low_ticks == CAL_MIN[7:0])
          cal_pending <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; relays, lamps and status refreshed on tick
  reg [6:0] contact;

  always @*
  begin
    contact = active ^ `RLY_INVERT_MASK;
  end

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      // Alarm-type contacts stay open until the first update.
      RELAY_CLOSED <= 7'h00;
      LAMP_ON <= 7'h00;
      CAL_START <= 1'b0;
      MEAS_STOP_GRANT <= 1'b0;
      SERVICE_REQ_STATUS <= 1'b0;
      SELECT_ERROR <= 1'b0;
    end
    else
    begin
      CAL_START <= din[`IN_CAL_LINE] ? 1'b0 :
                   (cal_pending | din[`IN_CAL_REQ]);
      MEAS_STOP_GRANT <= din[`IN_MEAS_REQ] & ~din[`IN_MAINT_BLOCK];
      if (tick)
      begin
        RELAY_CLOSED <= contact;
        LAMP_ON[`RLY_MAINT] <= u_maint | service_mode;
        LAMP_ON[`RLY_CUSTOM] <= custom_sig ^ lamp_invert;
        LAMP_ON[6:2] <= active[6:2];
        if (din[`IN_LAMP_TEST])
          LAMP_ON <= 7'h7F;
        SERVICE_REQ_STATUS <= service_status;
        SELECT_ERROR <= sel_bad;
      end
    end
  end

endmodule

/* File: testbench/op_unit.sv */
module op_unit
(
  input wire clk,
  input wire [9:0] want,
  output logic [9:0] u
);
  timeunit 1ns;
  timeprecision 1ps;
  initial u = 10'h000;
  // A unit that is not measuring never claims a valid value.
  always @(posedge clk)
    u <= {want[9:4], want[3] & want[9], want[2:0]};
endmodule

/* File: testbench/alarm_status_io_chk.sv */
module alarm_status_io_chk
#(
  parameter UPDATE_CYCLES = 20
)
(
  input wire CLOCK,
  input wire RSTN,
  input wire MAINT_BLOCK,
  input wire CAL_LINE,
  input wire SERVICE_SWITCH,
  input wire MEAS_STOP_REQ,
  input wire SEL_SERVICE_REQUIREMENT,
  input wire SEL_LOW_PRE_ALARM,
  input wire SEL_LOW_ALARM,
  input wire [6:0] RELAY_CLOSED,
  input wire [6:0] LAMP_ON,
  input wire CAL_START,
  input wire MEAS_STOP_GRANT,
  input wire SELECT_ERROR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  int svc_n;
  int sel_n;
  wire bad = SEL_SERVICE_REQUIREMENT + SEL_LOW_PRE_ALARM
    + SEL_LOW_ALARM != 2'h1;
  ////////////////////////////////////////
  // Inputs are filtered, so an effect lags a change by seven cycles; the checks wait eight.
  always_ff @(posedge CLOCK or negedge RSTN)
    if (!RSTN)
    begin
      svc_n <= 0;
      sel_n <= 0;
    end
    else
    begin
      svc_n <= SERVICE_SWITCH ? svc_n + 1 : 0;
      sel_n <= bad ? sel_n + 1 : 0;
    end
  chk_stop_block: assert property (
    MAINT_BLOCK [*8] |=> !MEAS_STOP_GRANT)
    else $error("stop granted while blocked");
  chk_stop_grant: assert property (
    (MEAS_STOP_REQ && !MAINT_BLOCK) [*8] |=> MEAS_STOP_GRANT)
    else $error("stop not granted");
  chk_stop_idle: assert property (
    !MEAS_STOP_REQ [*8] |=> !MEAS_STOP_GRANT)
    else $error("stop granted unasked");
  chk_cal_block: assert property (
    CAL_LINE [*8] |=> !CAL_START)
    else $error("calibration started while blocked");
  chk_relay_hold: assert property (
    $changed(RELAY_CLOSED) |=> $stable(RELAY_CLOSED) [*8])
    else $error("relays changed between updates");
  chk_reset_open: assert property (
    disable iff (1'b0) !RSTN && $past(RSTN) == 1'b0 |->
    RELAY_CLOSED == 7'h00 && LAMP_ON == 7'h00)
    else $error("outputs not open in reset");
  chk_service_out: assert property (
    svc_n > UPDATE_CYCLES + 20 |->
    RELAY_CLOSED[4:3] == 2'h1 && LAMP_ON[0])
    else $error("service outputs wrong");
  chk_select_err: assert property (
    sel_n > UPDATE_CYCLES + 20 |-> SELECT_ERROR)
    else $error("bad select not flagged");
endmodule
bind alarm_status_io alarm_status_io_chk
  #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk
(
  .CLOCK(CLOCK), .RSTN(RSTN), .MAINT_BLOCK(MAINT_BLOCK),
  .CAL_LINE(CAL_LINE), .SERVICE_SWITCH(SERVICE_SWITCH),
  .MEAS_STOP_REQ(MEAS_STOP_REQ),
  .SEL_SERVICE_REQUIREMENT(SEL_SERVICE_REQUIREMENT),
  .SEL_LOW_PRE_ALARM(SEL_LOW_PRE_ALARM), .SEL_LOW_ALARM(SEL_LOW_ALARM),
  .RELAY_CLOSED(RELAY_CLOSED), .LAMP_ON(LAMP_ON), .CAL_START(CAL_START),
  .MEAS_STOP_GRANT(MEAS_STOP_GRANT), .SELECT_ERROR(SELECT_ERROR)
);

/* File: testbench/alarm_status_io_tb.sv */
module alarm_status_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ar, lt, sw, mb, cl, gf, ef, sr, mc, am, pol, ed, xa;
  logic [2:0] sel;
  logic [9:0] want;
  logic [9:0] u;
  logic [6:0] rly;
  logic [6:0] lamp;
  logic cs, sg, ss, se;
  int n_errors = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  op_unit u_unit (.clk(clk), .want(want), .u(u));
  alarm_status_io #(.UPDATE_CYCLES(20), .DEBOUNCE(16'h0002)) u_dut
  (
    .CLOCK(clk), .RSTN(rstn), .ALARM_RESET(ar), .LAMP_TEST(lt),
    .SERVICE_SWITCH(sw), .MAINT_BLOCK(mb), .CAL_LINE(cl),
    .GAS_FAULT(gf), .EXT_FAULT(ef), .MEAS_STOP_REQ(sr),
    .MENU_CAL_REQ(mc), .SEL_SERVICE_REQUIREMENT(sel[0]),
    .SEL_LOW_PRE_ALARM(sel[1]), .SEL_LOW_ALARM(sel[2]),
    .ALARM_MODE_SELECT(am), .CUSTOM_LAMP_POLARITY_SELECT(pol),
    .EXT_MALFUNCTION_DISABLE(ed),
    .EXTERNAL_AUTO_CALIBRATION_MODE(xa),
    .UNIT_MAINTENANCE(u[0]), .UNIT_SERVICE_REQ(u[1]),
    .UNIT_FAILURE(u[2]), .UNIT_VALID(u[3]), .UNIT_PRE_ALARM(u[4]),
    .UNIT_LOW_PRE_ALARM(u[5]), .UNIT_LOW_ALARM(u[6]),
    .UNIT_CALIBRATING(u[7]), .UNIT_ALARM(u[8]),
    .UNIT_MEASURING(u[9]), .RELAY_CLOSED(rly), .LAMP_ON(lamp),
    .CAL_START(cs), .MEAS_STOP_GRANT(sg),
    .SERVICE_REQ_STATUS(ss), .SELECT_ERROR(se)
  );
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [6:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Three and a half update periods cover the input filter and one refresh.
  task automatic upd;
    repeat (70) @(negedge clk);
  endtask
  task automatic rst;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    chk("rly_rst", rly, 7'h00);
    rstn = 1'b1;
  endtask
  task automatic wait_hi(input bit pick);
    int k;
    for (k = 0; k < 200 && !(pick ? sg : cs); k++)
      @(negedge clk);
    if (k == 200)
    begin
      n_errors++;
      print_verdict;
    end
  endtask
  task automatic t_boot;
    rst;
    upd;
    chk("boot", rly, 7'h14);
    want = 10'h208;
    upd;
    chk("measure", rly, 7'h5C);
  endtask
  task automatic t_alarm(input logic man);
    if (man)
    begin
      am = 1'b1;
      rst;
    end
    want = man ? 10'h208 : 10'h308;
    upd;
    want = 10'h208;
    upd;
    chk("latched", rly[6], 1'b0);
    ar = 1'b1;
    upd;
    ar = 1'b0;
    upd;
    chk("ack", rly[6], 1'b1);
    am = 1'b0;
  endtask
  task automatic t_custom;
    int fb[3] = '{1, 5, 6};
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 3; j++)
      begin
        sel = 3'h1 << i;
        want = 10'h208 | (10'h001 << fb[j]);
        upd;
        chk("custom", rly[1], i == j);
        chk("sel_ok", se, 1'b0);
      end
    sel = 3'h3;
    want = 10'h20A;
    upd;
    chk("fallback", rly[1], 1'b1);
    sel = 3'h0;
    upd;
    chk("sel_err", se, 1'b1);
    sel = 3'h1;
    want = 10'h208;
    pol = 1'b1;
    upd;
    chk("pol_off", lamp[1], 1'b1);
    want = 10'h20A;
    upd;
    chk("pol_on", lamp[1], 1'b0);
    pol = 1'b0;
    upd;
    chk("lamp_on", lamp[1], 1'b1);
    want = 10'h208;
  endtask
  task automatic t_inputs;
    gf = 1'b1;
    upd;
    chk("gas", {ss, rly[1]}, 2'h3);
    gf = 1'b0;
    ef = 1'b1;
    upd;
    chk("ext", rly, 7'h58);
    ed = 1'b1;
    upd;
    chk("ext_off", rly, 7'h5C);
    ef = 1'b0;
    ed = 1'b0;
    lt = 1'b1;
    upd;
    chk("lamps", lamp, 7'h7F);
    chk("lt_rly", rly, 7'h5C);
    lt = 1'b0;
    want = 10'h299;
    upd;
    chk("status_rly", rly, 7'h6D);
    chk("status_lamp", lamp, 7'h39);
    want = 10'h208;
  endtask
  task automatic t_svc;
    want = 10'h205;
    sw = 1'b1;
    upd;
    chk("svc", rly, 7'h4C);
    chk("svc_lamp", lamp[0], 1'b1);
    want = 10'h305;
    upd;
    chk("svc_al", rly[6], 1'b0);
    want = 10'h205;
    upd;
    chk("svc_free", rly[6], 1'b1);
    ar = 1'b1;
    sw = 1'b0;
    want = 10'h208;
    upd;
    ar = 1'b0;
  endtask
  task automatic t_req;
    cl = 1'b1;
    mc = 1'b1;
    repeat (40) @(negedge clk);
    chk("cal_blk", cs, 1'b0);
    cl = 1'b0;
    wait_hi(1'b0);
    chk("cal", cs, 1'b1);
    mc = 1'b0;
    mb = 1'b1;
    sr = 1'b1;
    repeat (20) @(negedge clk);
    chk("stop_blk", sg, 1'b0);
    mb = 1'b0;
    wait_hi(1'b1);
    chk("stop", sg, 1'b1);
    repeat (10) @(negedge clk);
    sr = 1'b0;
    repeat (20) @(negedge clk);
    sr = 1'b1;
    @(negedge clk);
    sr = 1'b0;
    repeat (20) @(negedge clk);
    chk("glitch", sg, 1'b0);
  endtask
  task automatic t_ext;
    cl = 1'b1;
    xa = 1'b1;
    repeat (40) @(negedge clk);
    cl = 1'b0;
    repeat (80) @(negedge clk);
    chk("ext_early", cs, 1'b0);
    wait_hi(1'b0);
    chk("ext_cal", cs, 1'b1);
    @(negedge clk);
    chk("ext_once", cs, 1'b0);
    cl = 1'b1;
    xa = 1'b0;
    repeat (20) @(negedge clk);
  endtask
  initial
  begin
    {ar, lt, sw, mb, cl, gf, ef, sr, mc, am, pol, ed, xa} = 13'h0000;
    sel = 3'h1;
    want = 10'h000;
    t_boot;
    t_alarm(1'b0);
    t_custom;
    t_inputs;
    t_svc;
    t_req;
    t_ext;
    t_alarm(1'b1);
    print_verdict;
  end
endmodule
